// file: design/ldc_regs.sv
`timescale 1ns/1ps
// Function
// - Direction bit: 0 source, 1 sink
// - Table-1 direct row at 81h
// - Table-1 direct select picks direct row
// - Table-1 address is 90h plus row
// - Table-2 direct row at 82h
// - Table-2 direct select picks direct row
// - Table-2 address is D0h plus row
// - DAC-1 direct code at 83h
// - DAC-1 direct select picks direct code
// - DAC-2 direct code at 84h
// - DAC-2 direct select picks direct code
// - Path select register at 85h, nonvolatile
// - Write enable latch bit 7 at 86h
// - Addresses 88h to 8Fh reserved
// - Converter result readable at 87h, bits 7:2
// - Writes other than to 86h need latch set, else no acknowledge
// - Volatility bit decides nonvolatile copy write for 81h to 84h; 80h and 85h always written
// - Reserved bits ignored, written as zero, except at 80h, where they are stored as written
module ldc_regs
  import ldc_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  // Register access from serial port engine
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_ACK,
  output logic            REG_NACK,
  output logic            REG_BUSY,
  // Converter and table data
  input  wire logic [5:0] ADC_RESULT,
  input  wire logic [7:0] TABLE1_DATA,
  input  wire logic [7:0] TABLE2_DATA,
  // Analog controls
  output logic      [8:0] TABLE1_ROW_ADDR,
  output logic      [8:0] TABLE2_ROW_ADDR,
  output logic      [7:0] DAC_ONE_CODE,
  output logic      [7:0] DAC_TWO_CODE,
  output logic            GEN2_SINK,
  output logic      [1:0] GEN1_FULLSCALE,
  output logic      [1:0] GEN2_FULLSCALE
);
  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    reg_index = addr[2:0];
  endfunction : reg_index

  function automatic logic [8:0] row_addr(input logic [8:0] base, input logic [5:0] row);
    row_addr = base + {3'h0, row};
  endfunction : row_addr

  // ****************************************************************
  // State
  // ****************************************************************
  ldc_state_t state;
  ldc_state_t next_state;
  logic [2:0] recall_idx;
  logic [7:0] vol [0:NUM_STORED-1];
  logic       write_enable_latch;
  logic [5:0] adc_s1, adc_s2, adc_s3;
  logic [5:0] converter_result;
  logic [7:0] nv_rdata;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire        idle        = (state == ST_IDLE);
  wire        in_bank     = (REG_ADDR[7:4] == BANK_HI);
  wire [2:0]  widx        = reg_index(REG_ADDR);
  wire        is_wel_reg  = (REG_ADDR == ADDR_WEN_CTL);
  wire        is_stored   = in_bank && (REG_ADDR <= ADDR_PATH_SEL);
  wire        is_row_reg  = (REG_ADDR == ADDR_T1_ROW) || (REG_ADDR == ADDR_T2_ROW);
  wire        is_nv_only  = (REG_ADDR == ADDR_CTL0) || (REG_ADDR == ADDR_PATH_SEL);
  wire        vol_mode    = vol[IDX_CTL0][BIT_VOL_MODE];
  wire        wr_take     = idle && REG_WR && in_bank;
  wire        rd_take     = idle && REG_RD && !REG_WR && in_bank;
  wire        wr_allowed  = write_enable_latch || is_wel_reg;
  wire        stored_we   = wr_take && wr_allowed && is_stored;
  wire [7:0]  wr_byte     = is_row_reg ? (REG_WDATA & ROW_MASK) : REG_WDATA;
  wire        nv_we       = stored_we && (is_nv_only || vol_mode);
  wire [2:0]  nv_raddr    = recall_idx;

  // Read mux; reserved addresses and reserved bits outside 80h read as zero
  logic [7:0] rd_byte;
  always_comb begin
    if (is_stored) begin
      rd_byte = vol[widx];
    end else if (is_wel_reg) begin
      rd_byte = write_enable_latch ? WEL_MASK : RST_BYTE;
    end else if (REG_ADDR == ADDR_STATUS) begin
      rd_byte = {converter_result, 2'b00};
    end else begin
      rd_byte = RST_BYTE;
    end
  end

  // Data path selection
  wire [5:0] t1_row = vol[IDX_PATH_SEL][BIT_T1_DSEL] ? vol[IDX_T1_ROW][5:0]
                                                     : converter_result;
  wire [5:0] t2_row = vol[IDX_PATH_SEL][BIT_T2_DSEL] ? vol[IDX_T2_ROW][5:0]
                                                     : converter_result;
  wire [8:0] next_t1_addr = row_addr(T1_BASE, t1_row);
  wire [8:0] next_t2_addr = row_addr(T2_BASE, t2_row);
  wire [7:0] next_dac_one = vol[IDX_PATH_SEL][BIT_DAC_ONE_DSEL] ? vol[IDX_DAC_ONE_CODE]
                                                          : TABLE1_DATA;
  wire [7:0] next_dac_two = vol[IDX_PATH_SEL][BIT_DAC_TWO_DSEL] ? vol[IDX_DAC_TWO_CODE]
                                                          : TABLE2_DATA;

  // ****************************************************************
  // Recall sequencer: copy retained bytes into working registers
  // ****************************************************************
  wire recall_last = (recall_idx == 3'(NUM_STORED - 1));

  always_comb begin
    case (state)
      ST_RECALL_ADDR: next_state = ST_RECALL_DATA;
      ST_RECALL_DATA: next_state = recall_last ? ST_IDLE : ST_RECALL_ADDR;
      ST_IDLE:        next_state = ST_IDLE;
      default:        next_state = ST_RECALL_ADDR;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      state      <= ST_RECALL_ADDR;
      recall_idx <= 3'h0;
    end else begin
      state <= next_state;
      if (state == ST_RECALL_DATA) begin
        recall_idx <= recall_idx + 3'h1;
      end
    end
  end

  ldc_nv_store #(.WIDTH(8), .DEPTH(8), .AW(3)) u_nv (
    .clk   (CORE_CLK),
    .we    (nv_we),
    .waddr (widx),
    .wdata (wr_byte),
    .raddr (nv_raddr),
    .rdata (nv_rdata)
  );

  // ****************************************************************
  // Working registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_STORED; i++) begin
        vol[i] <= RST_BYTE;
      end
    end else if (state == ST_RECALL_DATA) begin
      vol[recall_idx] <= nv_rdata;
    end else if (stored_we) begin
      vol[widx] <= wr_byte;
    end
  end

  // Latch starts cleared; only bit 7 of the write matters
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      write_enable_latch <= 1'b0;
    end else if (wr_take && is_wel_reg) begin
      write_enable_latch <= REG_WDATA[BIT_WEL];
    end
  end

  // Converter result: accepted once stages two and three agree
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      adc_s1           <= RST_ADC;
      adc_s2           <= RST_ADC;
      adc_s3           <= RST_ADC;
      converter_result <= RST_ADC;
    end else begin
      adc_s1 <= ADC_RESULT;
      adc_s2 <= adc_s1;
      adc_s3 <= adc_s2;
      if (adc_s2 == adc_s3) begin
        converter_result <= adc_s3;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      REG_RDATA <= RST_BYTE;
      REG_ACK   <= 1'b0;
      REG_NACK  <= 1'b0;
      REG_BUSY  <= 1'b1;
    end else begin
      REG_ACK   <= (wr_take && wr_allowed) || rd_take;
      REG_NACK  <= wr_take && !wr_allowed;
      REG_BUSY  <= (next_state != ST_IDLE);
      if (rd_take) begin
        REG_RDATA <= rd_byte;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      TABLE1_ROW_ADDR <= T1_BASE;
      TABLE2_ROW_ADDR <= T2_BASE;
      DAC_ONE_CODE       <= RST_BYTE;
      DAC_TWO_CODE       <= RST_BYTE;
      GEN2_SINK       <= 1'b0;
      GEN1_FULLSCALE  <= 2'b00;
      GEN2_FULLSCALE  <= 2'b00;
    end else begin
      TABLE1_ROW_ADDR <= next_t1_addr;
      TABLE2_ROW_ADDR <= next_t2_addr;
      DAC_ONE_CODE       <= next_dac_one;
      DAC_TWO_CODE       <= next_dac_two;
      GEN2_SINK       <= vol[IDX_CTL0][BIT_GEN2_DIR];
      GEN1_FULLSCALE  <= vol[IDX_PATH_SEL][POS_GEN1_FS +: 2];
      GEN2_FULLSCALE  <= vol[IDX_PATH_SEL][POS_GEN2_FS +: 2];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_locked_write;
    idle && REG_WR && in_bank && !is_wel_reg && !write_enable_latch;
  endsequence

  sequence s_open_write(logic [7:0] a);
    idle && REG_WR && write_enable_latch && REG_ADDR == a;
  endsequence

  sequence s_reserved_write;
    idle && REG_WR && in_bank && REG_ADDR[3];
  endsequence

  // Path select write, then one cycle for the outputs to follow
  sequence s_fullscale_update;
    s_open_write(ADDR_PATH_SEL) ##1 idle;
  endsequence

  a_locked_nack: assert property (s_locked_write |=> REG_NACK && !REG_ACK)
    else $error("locked write not refused");
  a_locked_hold: assert property (s_locked_write |=> $stable(vol[IDX_PATH_SEL]))
    else $error("locked write changed a register");
  a_gen2_dir: assert property (idle && vol[IDX_CTL0][BIT_GEN2_DIR] |=> GEN2_SINK)
    else $error("generator 2 not sinking");
  a_gen2_src: assert property (idle && !vol[IDX_CTL0][BIT_GEN2_DIR] |=> !GEN2_SINK)
    else $error("generator 2 not sourcing");
  a_t1_addr: assert property (idle && vol[IDX_PATH_SEL][BIT_T1_DSEL] |=>
      TABLE1_ROW_ADDR == T1_BASE + {3'h0, $past(vol[IDX_T1_ROW][5:0])})
    else $error("table 1 direct address wrong");
  a_t1_adc: assert property (idle && !vol[IDX_PATH_SEL][BIT_T1_DSEL] |=>
      TABLE1_ROW_ADDR == T1_BASE + {3'h0, $past(converter_result)})
    else $error("table 1 converter address wrong");
  a_t2_addr: assert property (idle && !vol[IDX_PATH_SEL][BIT_T2_DSEL] |=>
      TABLE2_ROW_ADDR == T2_BASE + {3'h0, $past(converter_result)})
    else $error("table 2 converter address wrong");
  a_t2_dir: assert property (idle && vol[IDX_PATH_SEL][BIT_T2_DSEL] |=>
      TABLE2_ROW_ADDR == T2_BASE + {3'h0, $past(vol[IDX_T2_ROW][5:0])})
    else $error("table 2 direct address wrong");
  a_dac_one_sel: assert property (idle && vol[IDX_PATH_SEL][BIT_DAC_ONE_DSEL] |=>
      DAC_ONE_CODE == $past(vol[IDX_DAC_ONE_CODE]))
    else $error("dac one direct code not used");
  a_dac_one_tbl: assert property (idle && !vol[IDX_PATH_SEL][BIT_DAC_ONE_DSEL] |=>
      DAC_ONE_CODE == $past(TABLE1_DATA))
    else $error("dac one table data not used");
  a_dac_two_sel: assert property (idle && !vol[IDX_PATH_SEL][BIT_DAC_TWO_DSEL] |=>
      DAC_TWO_CODE == $past(TABLE2_DATA))
    else $error("dac two table data not used");
  a_dac_two_dir: assert property (idle && vol[IDX_PATH_SEL][BIT_DAC_TWO_DSEL] |=>
      DAC_TWO_CODE == $past(vol[IDX_DAC_TWO_CODE]))
    else $error("dac two direct code not used");
  a_row_write: assert property (s_open_write(ADDR_T1_ROW) |=>
      vol[IDX_T1_ROW] == ($past(REG_WDATA) & ROW_MASK))
    else $error("table 1 row write lost");
  a_vol_mode: assert property (s_open_write(ADDR_DAC_TWO_CODE) && !vol_mode |-> !nv_we)
    else $error("volatile write reached retained copy");
  a_direct_nv: assert property (s_open_write(ADDR_DAC_ONE_CODE) && vol_mode |-> nv_we)
    else $error("retained copy not written");
  a_path_nv: assert property (s_open_write(ADDR_PATH_SEL) |-> nv_we)
    else $error("path select not retained");
  a_wel_write: assert property (idle && REG_WR && is_wel_reg |=>
      write_enable_latch == $past(REG_WDATA[BIT_WEL]))
    else $error("write enable latch not updated");
  a_rsvd_hold: assert property (s_reserved_write |=>
      $stable(vol[IDX_DAC_ONE_CODE]) && $stable(write_enable_latch))
    else $error("reserved write changed state");
  a_reserved_rd: assert property (rd_take && REG_ADDR[3] |=>
      REG_RDATA == 8'h00 ##0 REG_ACK)
    else $error("reserved address read nonzero");
  a_status_rd: assert property (rd_take && REG_ADDR == ADDR_STATUS |=>
      REG_RDATA[1:0] == 2'b00 && REG_RDATA[7:2] == $past(converter_result))
    else $error("status read wrong");
  a_fullscale: assert property (s_fullscale_update |=>
      GEN1_FULLSCALE == $past(REG_WDATA[POS_GEN1_FS +: 2], 2) &&
      GEN2_FULLSCALE == $past(REG_WDATA[POS_GEN2_FS +: 2], 2))
    else $error("full scale selectors wrong");
endmodule : ldc_regs

// file: design/ldc_pkg.sv
package ldc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTL0      = 8'h80;
  localparam logic [7:0] ADDR_T1_ROW    = 8'h81;
  localparam logic [7:0] ADDR_T2_ROW    = 8'h82;
  localparam logic [7:0] ADDR_DAC_ONE_CODE = 8'h83;
  localparam logic [7:0] ADDR_DAC_TWO_CODE = 8'h84;
  localparam logic [7:0] ADDR_PATH_SEL  = 8'h85;
  localparam logic [7:0] ADDR_WEN_CTL   = 8'h86;
  localparam logic [7:0] ADDR_STATUS    = 8'h87;
  localparam logic [3:0] BANK_HI        = 4'h8;
  // Register bank indexes (address low bits)
  localparam logic [2:0] IDX_CTL0       = 3'h0;
  localparam logic [2:0] IDX_T1_ROW     = 3'h1;
  localparam logic [2:0] IDX_T2_ROW     = 3'h2;
  localparam logic [2:0] IDX_DAC_ONE_CODE  = 3'h3;
  localparam logic [2:0] IDX_DAC_TWO_CODE  = 3'h4;
  localparam logic [2:0] IDX_PATH_SEL   = 3'h5;
  localparam int         NUM_STORED     = 6;
  // Field positions
  localparam int BIT_GEN2_DIR   = 7;
  localparam int BIT_VOL_MODE   = 5;
  localparam int BIT_DAC_TWO_DSEL  = 7;
  localparam int BIT_T2_DSEL    = 6;
  localparam int BIT_DAC_ONE_DSEL  = 5;
  localparam int BIT_T1_DSEL    = 4;
  localparam int BIT_WEL        = 7;
  localparam int POS_GEN2_FS    = 2;
  localparam int POS_GEN1_FS    = 0;
  localparam logic [7:0] ROW_MASK    = 8'h3f;
  localparam logic [7:0] WEL_MASK    = 8'h80;
  // Table base addresses
  localparam logic [8:0] T1_BASE     = 9'h090;
  localparam logic [8:0] T2_BASE     = 9'h0d0;
  // Reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [5:0] RST_ADC     = 6'h00;

  typedef enum logic [1:0] {
    ST_RECALL_ADDR = 2'b00,
    ST_RECALL_DATA = 2'b01,
    ST_IDLE        = 2'b10
  } ldc_state_t;
endpackage : ldc_pkg

// file: design/ldc_nv_store.sv
`timescale 1ns/1ps
module ldc_nv_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  // Retained cells, not cleared by reset
  logic [WIDTH-1:0] cells [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    rdata <= cells[raddr];
  end
endmodule : ldc_nv_store

// file: bench/ldc_table_model.sv
`timescale 1ns/1ps
// ****************************************
// Lookup table rows
// ****************************************
module ldc_table_model (
  // Row addresses
  input  wire logic [8:0] row1,
  input  wire logic [8:0] row2,
  // Row data
  output logic      [7:0] data1,
  output logic      [7:0] data2
);
  // Distinct pattern per row
  assign data1 = row1[7:0] ^ 8'h3c;
  assign data2 = row2[7:0] ^ 8'hc3;
endmodule : ldc_table_model

// file: bench/ldc_regs_tb.sv
`timescale 1ns/1ps
module ldc_regs_tb
  import ldc_pkg::*;
;
  logic       clk, rstn, wr, rd, ack, nack, busy, sink;
  logic [7:0] addr, wdata, rdata, t1d, t2d, dac_one, dac_two, q;
  logic [5:0] adc;
  logic [8:0] row1, row2;
  logic [1:0] fs1, fs2;
  int         fails, comparisons, cycles;

  ldc_regs ldc_regs_i (.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_ACK(ack), .REG_NACK(nack),
    .REG_BUSY(busy), .ADC_RESULT(adc), .TABLE1_DATA(t1d), .TABLE2_DATA(t2d),
    .TABLE1_ROW_ADDR(row1), .TABLE2_ROW_ADDR(row2), .DAC_ONE_CODE(dac_one), .DAC_TWO_CODE(dac_two),
    .GEN2_SINK(sink), .GEN1_FULLSCALE(fs1), .GEN2_FULLSCALE(fs2));
  ldc_table_model ldc_table_model_i (.row1(row1), .row2(row2), .data1(t1d), .data2(t2d));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic refuse);
    @(negedge clk);
    wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
    chk("ack", {8'h00, ack}, {8'h00, ~refuse});
    chk("nack", {8'h00, nack}, {8'h00, refuse});
  endtask : acc

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00, 1'b0);
    chk(what, {1'b0, q}, {1'b0, exp});
  endtask : rchk

  task automatic do_reset;
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    chk("busy", {8'h00, busy}, 9'h000);
  endtask : do_reset

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_setup;
    acc(1'b1, ADDR_WEN_CTL, WEL_MASK, 1'b0);
    rchk("wen", ADDR_WEN_CTL, 8'h80);
    acc(1'b1, ADDR_CTL0, 8'h20, 1'b0);
    acc(1'b1, ADDR_T1_ROW, 8'h3f, 1'b0);
    acc(1'b1, ADDR_T2_ROW, 8'h05, 1'b0);
    acc(1'b1, ADDR_DAC_ONE_CODE, 8'hc3, 1'b0);
    acc(1'b1, ADDR_DAC_TWO_CODE, 8'h5a, 1'b0);
    acc(1'b1, ADDR_PATH_SEL, 8'h00, 1'b0);
    // Locked write once every working register holds a known value
    acc(1'b1, ADDR_WEN_CTL, 8'h00, 1'b0);
    acc(1'b1, ADDR_DAC_ONE_CODE, 8'h11, 1'b1);
    acc(1'b1, ADDR_WEN_CTL, WEL_MASK, 1'b0);
    rchk("row1", ADDR_T1_ROW, 8'h3f);
    rchk("row2", ADDR_T2_ROW, 8'h05);
    rchk("code1", ADDR_DAC_ONE_CODE, 8'hc3);
    rchk("code2", ADDR_DAC_TWO_CODE, 8'h5a);
    rchk("path", ADDR_PATH_SEL, 8'h00);
    $display("test setup done");
  endtask : t_setup

  task automatic t_path;
    adc = 6'h12;
    repeat (8) @(negedge clk);
    chk("t1 adc", row1, T1_BASE + 9'h012);
    chk("t2 adc", row2, T2_BASE + 9'h012);
    chk("dac_one tbl", {1'b0, dac_one}, {1'b0, 8'ha2 ^ 8'h3c});
    chk("dac_two tbl", {1'b0, dac_two}, {1'b0, 8'he2 ^ 8'hc3});
    acc(1'b1, ADDR_PATH_SEL, 8'hf0, 1'b0);
    repeat (3) @(negedge clk);
    chk("t1 dir", row1, 9'h0cf);
    chk("t2 dir", row2, 9'h0d5);
    chk("dac_one dir", {1'b0, dac_one}, 9'h0c3);
    chk("dac_two dir", {1'b0, dac_two}, 9'h05a);
    acc(1'b1, ADDR_PATH_SEL, 8'h0e, 1'b0);
    repeat (3) @(negedge clk);
    chk("fs1", {7'h00, fs1}, 9'h002);
    chk("fs2", {7'h00, fs2}, 9'h003);
    chk("t1 back", row1, T1_BASE + 9'h012);
    acc(1'b1, ADDR_CTL0, 8'ha0, 1'b0);
    repeat (3) @(negedge clk);
    chk("sink", {8'h00, sink}, 9'h001);
    acc(1'b1, ADDR_CTL0, 8'h20, 1'b0);
    repeat (3) @(negedge clk);
    chk("source", {8'h00, sink}, 9'h000);
    $display("test path done");
  endtask : t_path

  task automatic t_status;
    adc = 6'h2b;
    repeat (8) @(negedge clk);
    rchk("status", ADDR_STATUS, 8'hac);
    acc(1'b1, ADDR_STATUS, 8'h00, 1'b0);
    rchk("status ro", ADDR_STATUS, 8'hac);
    for (int a = 8'h88; a <= 8'h8f; a++) begin
      acc(1'b1, 8'(a), 8'hff, 1'b0);
      rchk("rsvd", 8'(a), 8'h00);
    end
    rchk("code1 kept", ADDR_DAC_ONE_CODE, 8'hc3);
    $display("test status done");
  endtask : t_status

  task automatic t_volatile;
    acc(1'b1, ADDR_CTL0, 8'h00, 1'b0);
    acc(1'b1, ADDR_DAC_TWO_CODE, 8'h77, 1'b0);
    rchk("code2 vol", ADDR_DAC_TWO_CODE, 8'h77);
    acc(1'b1, ADDR_WEN_CTL, 8'h00, 1'b0);
    acc(1'b1, ADDR_DAC_ONE_CODE, 8'h99, 1'b1);
    rchk("code1 held", ADDR_DAC_ONE_CODE, 8'hc3);
    do_reset();
    rchk("code1 nv", ADDR_DAC_ONE_CODE, 8'hc3);
    rchk("code2 nv", ADDR_DAC_TWO_CODE, 8'h5a);
    rchk("wen clr", ADDR_WEN_CTL, 8'h00);
    acc(1'b1, ADDR_DAC_TWO_CODE, 8'h01, 1'b1);
    $display("test volatile done");
  endtask : t_volatile

  initial begin
    {wr, rd, rstn} = 3'b000;
    {addr, wdata} = 16'h0000;
    adc = 6'h00;
    {fails, comparisons, cycles} = '0;
    do_reset();
    t_setup();
    t_path();
    t_status();
    t_volatile();
    report_and_stop();
  end
endmodule : ldc_regs_tb
